// >>> uart_chan_consts.svh
// timing counts, register offsets, field positions and reset values of the serial channel
`ifndef UART_CHAN_CONSTS_SVH
`define UART_CHAN_CONSTS_SVH
`define REF_CLK_HZ 100000000
`define MAX_RATE_BPS 1500000
`define OVERSAMPLE 16
`define REG_DATA 4'h0
`define REG_LINE_CTRL 4'h1
`define REG_MODEM_CTRL 4'h2
`define REG_DIV_LO 4'h3
`define REG_DIV_HI 4'h4
`define REG_FIFO_CTRL 4'h5
`define REG_LINE_STATUS 4'h6
`define REG_IRQ_STATUS 4'h7
`define REG_IRQ_MASK 4'h8
`define REG_MONITOR 4'h9
`define REG_FLOW 4'hA
`define MCR_IRQ_GATE 3
`define MCR_ANY_RESUME 5
`define MCR_IR_MODE 6
`define MCR_PRESCALE4 7
`define LCR_PARITY_EN 0
`define LCR_PARITY_EVEN 1
`define LCR_TWO_STOP 2
`define LCR_TX_EN 3
`define EV_RX_TRIG 0
`define EV_TX_TRIG 1
`define EV_PARITY_ERR 2
`define EV_FRAME_ERR 3
`define EV_OVERRUN 4
`define DIV_RESET 16'h0001
`define TRIG_L0 8'h01
`define TRIG_L1 8'h20
`define TRIG_L2 8'h40
`define TRIG_L3 8'h78
`endif

// >>> uart_chan_pkg.sv
// types of the serial channel
package uart_chan_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic [7:0] data;
  } rx_char_t;
endpackage

// >>> quad_uart_serial_channel.sv
// one serial channel: framing engine, fifos, modes and register port
// Summary of operation
// R1 - standard line: output high reset, idle, disabled
// R2 - remote keeps standard input high idle
// R3 - infrared mode idles low both directions
// R4 - modem control bit 6 selects infrared
// R5 - loopback feeds transmit stream to receiver
// R6 - framing with start and stop bits
// R7 - parity appended and checked
// R8 - separate 128 byte transmit and receive fifos
// R9 - four selectable fifo trigger levels
// R10 - bit 5: any character resumes flow
// R11 - style input and bit 3 gate interrupt
// R12 - prescale strap at init, bit 7 overrides
// R13 - monitor shows four channels' fifo flags
// R14 - up to 1.5 Mbps supported
// R15 - prescale option for higher rates; here bit 7 divides the reference by four more, lowering the rate
// R16 - start bit edge, mid-bit confirm
// R17 - framing and parity errors reported
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "uart_chan_consts.svh"
module quad_uart_serial_channel #(
  parameter int FIFO_DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic mclk,
  input wire logic rst,
  input wire uart_chan_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  input wire logic serial_in_line,
  output logic serial_out_line,
  input wire logic irq_style_select,
  input wire logic prescale_default_select,
  input wire logic loopback,
  input wire logic [3:0] other_tx_space_flag,
  input wire logic [3:0] other_rx_avail_flag,
  output logic tx_space_flag,
  output logic rx_avail_flag,
  output logic flow_suspended,
  output logic irq
);
  localparam int BAUD_MIN_DIV = `REF_CLK_HZ / (`MAX_RATE_BPS * `OVERSAMPLE);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] rx_sync;
  logic [1:0] style_sync;
  logic [1:0] strap_sync;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_sync <= 2'h0;
      style_sync <= 2'h0;
      strap_sync <= 2'h0;
    end else begin
      rx_sync <= {rx_sync[0], serial_in_line};
      style_sync <= {style_sync[0], irq_style_select};
      strap_sync <= {strap_sync[0], prescale_default_select};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] modem_control_reg;
  logic [7:0] line_ctrl;
  logic [15:0] divisor;
  logic [1:0] rx_trig_sel;
  logic [1:0] tx_trig_sel;
  logic [4:0] irq_status;
  logic [4:0] irq_mask;
  logic strap_taken;
  logic [1:0] strap_wait;
  logic wr_ok;
  assign wr_ok = bus.wr;
  // the strap is taken once the synchroniser has filled, then only software changes bit 7
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modem_control_reg <= 8'h00;
      strap_taken <= 1'b0;
      strap_wait <= 2'h0;
    end else if (!strap_taken) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        modem_control_reg[`MCR_PRESCALE4] <= strap_sync[1]; // [R12]
        strap_taken <= 1'b1;
      end
    end else if (wr_ok && bus.addr == `REG_MODEM_CTRL) begin
      modem_control_reg <= bus.wdata; // [R12]
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_ctrl <= 8'h08;
      divisor <= `DIV_RESET;
      rx_trig_sel <= 2'h0;
      tx_trig_sel <= 2'h0;
      irq_mask <= 5'h00;
    end else if (wr_ok) begin
      case (bus.addr)
        `REG_LINE_CTRL: line_ctrl <= bus.wdata;
        `REG_DIV_LO: divisor[7:0] <= bus.wdata;
        `REG_DIV_HI: divisor[15:8] <= bus.wdata;
        `REG_FIFO_CTRL: begin
          rx_trig_sel <= bus.wdata[1:0]; // [R9]
          tx_trig_sel <= bus.wdata[3:2]; // [R9]
        end
        `REG_IRQ_MASK: irq_mask <= bus.wdata[4:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // baud tick: 16 ticks a bit; 4x prescale divides the reference by four more
  logic [17:0] baud_cnt;
  logic [17:0] baud_top;
  logic tick;
  // divisor below the minimum is clamped, so the rate stops at 1.5625 Mbps, just over the 1.5 Mbps ceiling
  always_comb begin
    baud_top = (divisor < 16'(BAUD_MIN_DIV)) ? 18'(BAUD_MIN_DIV) : {2'h0, divisor};
    if (modem_control_reg[`MCR_PRESCALE4]) begin
      baud_top = {baud_top[15:0], 2'h0}; // [R15]
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      baud_cnt <= 18'h00000;
      tick <= 1'b0;
    end else if (baud_cnt + 18'h00001 >= baud_top) begin
      baud_cnt <= 18'h00000;
      tick <= 1'b1; // [R14]
    end else begin
      baud_cnt <= baud_cnt + 18'h00001;
      tick <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // fifos
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [9:0] rx_mem [FIFO_DEPTH];
  logic [AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [AW:0] tx_level, rx_level;
  logic tx_pop, rx_push;
  uart_chan_pkg::rx_char_t rx_char;
  uart_chan_pkg::rx_char_t rx_head;
  assign tx_level = tx_wp - tx_rp;
  assign rx_level = rx_wp - rx_rp;
  logic tx_full, rx_full, tx_push, rx_pop;
  assign tx_full = tx_level == (AW+1)'(FIFO_DEPTH);
  assign rx_full = rx_level == (AW+1)'(FIFO_DEPTH);
  assign tx_push = wr_ok && bus.addr == `REG_DATA && !tx_full;
  assign rx_pop = bus.rd && bus.addr == `REG_DATA && rx_level != '0;
  assign rx_head = rx_mem[rx_rp[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (tx_push) begin
      tx_mem[tx_wp[AW-1:0]] <= bus.wdata; // [R8]
    end
    if (rx_push && !rx_full) begin
      rx_mem[rx_wp[AW-1:0]] <= rx_char; // [R8]
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 1'b1;
      if (tx_pop) tx_rp <= tx_rp + 1'b1;
      if (rx_push && !rx_full) rx_wp <= rx_wp + 1'b1;
      if (rx_pop) rx_rp <= rx_rp + 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  uart_chan_pkg::tx_state_t tx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_bits;
  logic [3:0] tx_sub;
  logic tx_bit;
  logic [7:0] tx_byte;
  logic [3:0] tx_len;
  assign tx_byte = tx_mem[tx_rp[AW-1:0]];
  assign tx_pop = tx_state == uart_chan_pkg::TX_IDLE && tick && tx_level != '0
                  && line_ctrl[`LCR_TX_EN] && !flow_suspended;
  always_comb begin
    tx_len = 4'hA;
    if (line_ctrl[`LCR_PARITY_EN]) tx_len = tx_len + 4'h1;
    if (line_ctrl[`LCR_TWO_STOP]) tx_len = tx_len + 4'h1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_state <= uart_chan_pkg::TX_IDLE;
      tx_shift <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_sub <= 4'h0;
      tx_bit <= 1'b1; // [R1]
    end else begin
      case (tx_state)
        uart_chan_pkg::TX_IDLE: begin
          tx_bit <= 1'b1; // [R1]
          if (tx_pop) begin
            // lsb first: start, data, optional parity, stop ones fill the top
            if (line_ctrl[`LCR_PARITY_EN]) begin
              tx_shift <= {1'b1, ^tx_byte ^ !line_ctrl[`LCR_PARITY_EVEN], tx_byte, 1'b0}; // [R7]
            end else begin
              tx_shift <= {2'h3, tx_byte, 1'b0}; // [R6]
            end
            tx_bits <= tx_len;
            tx_sub <= 4'h0;
            tx_state <= uart_chan_pkg::TX_SHIFT;
          end
        end
        uart_chan_pkg::TX_SHIFT: begin
          if (tick) begin
            if (tx_sub == 4'h0) begin
              if (tx_bits == 4'h0) begin
                tx_state <= uart_chan_pkg::TX_IDLE;
                tx_bit <= 1'b1;
              end else begin
                tx_bit <= tx_shift[0]; // [R6]
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_bits <= tx_bits - 4'h1;
              end
            end
            tx_sub <= tx_sub + 4'h1;
          end
        end
        default: tx_state <= uart_chan_pkg::TX_IDLE;
      endcase
    end
  end
  // infrared: a short high pulse per zero bit, low when idle; disabled rests idle even mid-frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_out_line <= 1'b1; // [R1]
    end else if (modem_control_reg[`MCR_IR_MODE]) begin
      serial_out_line <= line_ctrl[`LCR_TX_EN] && !tx_bit
                         && tx_sub >= 4'h6 && tx_sub < 4'hA; // [R3] [R4]
    end else begin
      serial_out_line <= tx_bit || !line_ctrl[`LCR_TX_EN]; // [R1] [R4]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // receiver
  logic rx_line;
  logic rx_prev;
  uart_chan_pkg::rx_state_t rx_state;
  logic [3:0] rx_sub;
  logic [3:0] rx_cnt;
  logic [7:0] rx_data;
  logic rx_par;
  logic ir_seen;
  // normalise to standard polarity: infrared input idles low, a pulse marks a zero
  always_comb begin
    if (loopback) begin
      rx_line = tx_bit; // [R5]
    end else if (modem_control_reg[`MCR_IR_MODE]) begin
      rx_line = !(rx_sync[1] || ir_seen); // [R3] [R4]
    end else begin
      rx_line = rx_sync[1]; // [R2]
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ir_seen <= 1'b0;
    end else if (tick && (rx_sub == 4'hF
                 || (rx_state == uart_chan_pkg::RX_START && rx_sub == 4'h7))) begin
      ir_seen <= 1'b0;
    end else if (rx_sync[1]) begin
      ir_seen <= 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_state <= uart_chan_pkg::RX_IDLE;
      rx_prev <= 1'b1;
      rx_sub <= 4'h0;
      rx_cnt <= 4'h0;
      rx_data <= 8'h00;
      rx_par <= 1'b0;
      rx_push <= 1'b0;
      rx_char <= '0;
    end else begin
      rx_push <= 1'b0;
      rx_prev <= rx_line;
      case (rx_state)
        uart_chan_pkg::RX_IDLE: begin
          if (rx_prev && !rx_line) begin
            rx_sub <= 4'h0; // [R16]
            rx_state <= uart_chan_pkg::RX_START;
          end
        end
        uart_chan_pkg::RX_START: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'h7) begin
              rx_sub <= 4'h0;
              rx_cnt <= 4'h0;
              rx_state <= rx_line ? uart_chan_pkg::RX_IDLE : uart_chan_pkg::RX_DATA; // [R16]
            end
          end
        end
        uart_chan_pkg::RX_DATA: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'hF) begin
              if (rx_cnt < 4'h8) begin
                rx_data <= {rx_line, rx_data[7:1]}; // [R6]
              end else begin
                rx_par <= rx_line;
              end
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt == (line_ctrl[`LCR_PARITY_EN] ? 4'h8 : 4'h7)) begin
                rx_state <= uart_chan_pkg::RX_STOP;
              end
            end
          end
        end
        uart_chan_pkg::RX_STOP: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'hF) begin
              rx_char.data <= rx_data;
              rx_char.frame_err <= !rx_line; // [R17]
              rx_char.parity_err <= line_ctrl[`LCR_PARITY_EN]
                && ((^rx_data ^ !line_ctrl[`LCR_PARITY_EVEN]) != rx_par); // [R7] [R17]
              rx_push <= 1'b1;
              rx_state <= uart_chan_pkg::RX_IDLE;
            end
          end
        end
        default: rx_state <= uart_chan_pkg::RX_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // software flow suspension: set by writing, released by any character when enabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flow_suspended <= 1'b0;
    end else if (rx_push && modem_control_reg[`MCR_ANY_RESUME]) begin
      flow_suspended <= 1'b0; // [R10]
    end else if (wr_ok && bus.addr == `REG_FLOW) begin
      flow_suspended <= bus.wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // trigger levels, status and interrupt
  logic [7:0] rx_trig, tx_trig;
  logic [4:0] events;
  always_comb begin
    case (rx_trig_sel)
      2'h0: rx_trig = `TRIG_L0; // [R9]
      2'h1: rx_trig = `TRIG_L1;
      2'h2: rx_trig = `TRIG_L2;
      default: rx_trig = `TRIG_L3;
    endcase
    case (tx_trig_sel)
      2'h0: tx_trig = `TRIG_L0;
      2'h1: tx_trig = `TRIG_L1;
      2'h2: tx_trig = `TRIG_L2;
      default: tx_trig = `TRIG_L3;
    endcase
  end
  logic rx_at, tx_at, rx_at_d, tx_at_d;
  assign rx_at = 8'(rx_level) >= rx_trig;
  assign tx_at = 8'(FIFO_DEPTH) - 8'(tx_level) >= tx_trig;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_at_d <= 1'b0;
      tx_at_d <= 1'b0;
    end else begin
      rx_at_d <= rx_at;
      tx_at_d <= tx_at;
    end
  end
  always_comb begin
    events = 5'h00;
    events[`EV_RX_TRIG] = rx_at && !rx_at_d; // [R9]
    events[`EV_TX_TRIG] = tx_at && !tx_at_d;
    events[`EV_PARITY_ERR] = rx_push && rx_char.parity_err;
    events[`EV_FRAME_ERR] = rx_push && rx_char.frame_err;
    events[`EV_OVERRUN] = rx_push && rx_full;
  end
  // a new event in the clearing cycle stays set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status <= 5'h00;
    end else if (wr_ok && bus.addr == `REG_IRQ_STATUS) begin
      irq_status <= (irq_status & ~bus.wdata[4:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end
  // style input high: always enabled; low: gated by modem control bit 3
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask)
             && (style_sync[1] || modem_control_reg[`MCR_IRQ_GATE]); // [R11]
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_space_flag <= 1'b0;
      rx_avail_flag <= 1'b0;
    end else begin
      tx_space_flag <= !tx_full; // [R13]
      rx_avail_flag <= rx_level != '0; // [R13]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `REG_DATA: rdata <= rx_head.data;
        `REG_LINE_CTRL: rdata <= line_ctrl;
        `REG_MODEM_CTRL: rdata <= modem_control_reg;
        `REG_DIV_LO: rdata <= divisor[7:0];
        `REG_DIV_HI: rdata <= divisor[15:8];
        `REG_FIFO_CTRL: rdata <= {4'h0, tx_trig_sel, rx_trig_sel};
        `REG_LINE_STATUS: rdata <= {3'h0, rx_head.frame_err && rx_avail_flag,
                                    rx_head.parity_err && rx_avail_flag,
                                    flow_suspended, tx_space_flag, rx_avail_flag};
        `REG_IRQ_STATUS: rdata <= {3'h0, irq_status};
        `REG_IRQ_MASK: rdata <= {3'h0, irq_mask};
        `REG_MONITOR: rdata <= {other_rx_avail_flag[3:1], rx_avail_flag,
                                other_tx_space_flag[3:1], tx_space_flag}; // [R13]
        `REG_FLOW: rdata <= {7'h00, flow_suspended};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// >>> uart_chan_assertions.sv
// port-level assertions of the serial channel
`timescale 1ns/100ps
`include "uart_chan_consts.svh"
module uart_chan_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire uart_chan_pkg::bus_req_t bus,
  input wire logic [7:0] rdata,
  input wire logic serial_out_line,
  input wire logic irq_style_select,
  input wire logic [3:0] other_tx_space_flag,
  input wire logic [3:0] other_rx_avail_flag,
  input wire logic tx_space_flag,
  input wire logic rx_avail_flag,
  input wire logic flow_suspended,
  input wire logic irq
);
  logic [7:0] mcr_sh;
  logic [7:0] mask_sh;
  logic tx_en_sh;
  ////////////////////////////////////////
  // shadows of written control bits; the strap only touches bit 7, unused here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mcr_sh <= 8'h00;
      mask_sh <= 8'h00;
      tx_en_sh <= 1'h1;
    end else if (bus.wr) begin
      if (bus.addr == `REG_MODEM_CTRL) mcr_sh <= bus.wdata;
      if (bus.addr == `REG_IRQ_MASK) mask_sh <= bus.wdata;
      if (bus.addr == `REG_LINE_CTRL) tx_en_sh <= bus.wdata[`LCR_TX_EN];
    end
  end
  ////////////////////////////////////////
  // no disable here: the level during reset is the point
  a_reset_out_high: assert property (@(posedge mclk) rst |-> serial_out_line)
    else $error("serial output low in reset");
  // eight cycles cover the settling of the registered output after a write
  a_disabled_high: assert property (@(posedge mclk) disable iff (rst)
    (!tx_en_sh && !mcr_sh[`MCR_IR_MODE]) [*8] |-> serial_out_line)
    else $error("disabled standard output not high");
  a_ir_idle_low: assert property (@(posedge mclk) disable iff (rst)
    (!tx_en_sh && mcr_sh[`MCR_IR_MODE]) [*8] |-> !serial_out_line)
    else $error("disabled infrared output not low");
  a_irq_gated: assert property (@(posedge mclk) disable iff (rst)
    (!irq_style_select && !mcr_sh[`MCR_IRQ_GATE]) [*6] |-> !irq)
    else $error("interrupt not gated");
  a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
    (mask_sh == 8'h00) [*3] |-> !irq)
    else $error("interrupt with empty mask");
  a_monitor_read: assert property (@(posedge mclk) disable iff (rst)
    $past(bus.rd && bus.addr == `REG_MONITOR) |->
    rdata == {$past(other_rx_avail_flag[3:1]), $past(rx_avail_flag),
    $past(other_tx_space_flag[3:1]), $past(tx_space_flag)})
    else $error("monitor read differs from flags");
  a_status_flags: assert property (@(posedge mclk) disable iff (rst)
    $past(bus.rd && bus.addr == `REG_LINE_STATUS) |->
    rdata[1:0] == $past({tx_space_flag, rx_avail_flag}))
    else $error("line status fifo flags differ");
  a_flow_status: assert property (@(posedge mclk) disable iff (rst)
    $past(bus.rd && bus.addr == `REG_LINE_STATUS) |-> rdata[2] == $past(flow_suspended))
    else $error("line status flow bit differs");
  a_space_after_reset: assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> ##[1:3] (tx_space_flag && !rx_avail_flag))
    else $error("fifo flags wrong after reset");
endmodule
bind quad_uart_serial_channel uart_chan_checker u_chk (.mclk(mclk), .rst(rst), .bus(bus),
  .rdata(rdata), .serial_out_line(serial_out_line), .irq_style_select(irq_style_select),
  .other_tx_space_flag(other_tx_space_flag), .other_rx_avail_flag(other_rx_avail_flag),
  .tx_space_flag(tx_space_flag), .rx_avail_flag(rx_avail_flag),
  .flow_suspended(flow_suspended), .irq(irq));

// >>> remote_line.sv
// remote serial sender driving the channel's receive pin
`timescale 1ns/100ps
module remote_line #(
  parameter int BT = 64
) (
  input wire logic mclk,
  input wire logic ir,
  output logic line
);
  initial line = 1'h1;
  ////////////////////////////////////////
  // idle level follows the line mode
  task automatic park(input logic v);
    @(posedge mclk);
    line <= v;
  endtask
  // start, data lsb first, optional parity, stop; infrared pulses once per zero bit
  task automatic send(input logic [7:0] d, input logic pen, input logic par, input logic stp);
    logic [10:0] f;
    int n;
    f = pen ? {stp, par, d, 1'h0} : {1'h1, stp, d, 1'h0};
    n = pen ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < BT; c++) begin
        @(posedge mclk);
        line <= ir ? (!f[i] && c >= 6 * BT / 16 && c < 10 * BT / 16) : f[i];
      end
    end
    park(!ir);
  endtask
endmodule

// >>> quad_uart_serial_channel_test.sv
// self-checking bench of the serial channel
`timescale 1ns/100ps
`include "uart_chan_consts.svh"
module quad_uart_serial_channel_test;
  localparam int BT = 64;
  logic mclk = 1'h0;
  logic rst = 1'h0;
  uart_chan_pkg::bus_req_t bus = '0;
  logic [7:0] rdata;
  logic serial_in_line;
  logic serial_out_line;
  logic irq_style_select = 1'h1;
  logic prescale_default_select = 1'h1;
  logic loopback = 1'h0;
  logic [3:0] other_tx_space_flag = 4'hA;
  logic [3:0] other_rx_avail_flag = 4'h6;
  logic tx_space_flag;
  logic rx_avail_flag;
  logic flow_suspended;
  logic irq;
  logic ir = 1'h0;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  quad_uart_serial_channel u_quad_uart_serial_channel (.mclk(mclk), .rst(rst), .bus(bus),
    .rdata(rdata), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .irq_style_select(irq_style_select), .prescale_default_select(prescale_default_select),
    .loopback(loopback), .other_tx_space_flag(other_tx_space_flag),
    .other_rx_avail_flag(other_rx_avail_flag), .tx_space_flag(tx_space_flag),
    .rx_avail_flag(rx_avail_flag), .flow_suspended(flow_suspended), .irq(irq));
  remote_line #(.BT(BT)) u_remote_line (.mclk(mclk), .ir(ir), .line(serial_in_line));
  ////////////////////////////////////////
  task automatic final_report;
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge mclk);
    bus.wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge mclk);
    bus.rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // bounded wait so a lost character cannot hang the run
  task automatic wait_rx;
    for (int i = 0; i < 20 * BT && rx_avail_flag !== 1'h1; i++) @(posedge mclk);
    #1 chk(8'(rx_avail_flag), 8'h01);
  endtask
  task automatic drain;
    logic [7:0] d;
    repeat (130) if (rx_avail_flag === 1'h1) rd(`REG_DATA, d);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rc(`REG_MODEM_CTRL, 8'h80);
    wr(`REG_MODEM_CTRL, 8'h00);
    rc(`REG_MODEM_CTRL, 8'h00);
    rc(`REG_LINE_STATUS, 8'h02);
    rc(`REG_LINE_CTRL, 8'h08);
    rc(4'hF, 8'h00);
  endtask
  task automatic t_wire;
    logic [9:0] f;
    f = {1'h1, 8'h3C, 1'h0};
    wr(`REG_DATA, 8'h3C);
    for (int i = 0; i < 20 * BT && serial_out_line !== 1'h0; i++) @(posedge mclk);
    step(BT / 2);
    for (int i = 0; i < 10; i++) begin
      chk(8'(serial_out_line), 8'(f[i]));
      step(BT);
    end
  endtask
  // the pin is parked low: if it were heard, zero characters would arrive
  task automatic t_loop;
    u_remote_line.park(1'h0);
    loopback <= 1'h1;
    wr(`REG_LINE_CTRL, 8'h0B);
    wr(`REG_DATA, 8'hA5);
    wait_rx;
    rc(`REG_LINE_STATUS, 8'h03);
    rc(`REG_DATA, 8'hA5);
    step(3);
    chk(8'(rx_avail_flag), 8'h00);
    u_remote_line.park(1'h1);
    repeat (8) @(posedge mclk);
    loopback <= 1'h0;
  endtask
  task automatic t_rx;
    logic [7:0] d;
    u_remote_line.send(8'h5A, 1'h1, 1'h0, 1'h1);
    wait_rx;
    rc(`REG_LINE_STATUS, 8'h03);
    rd(`REG_IRQ_STATUS, d);
    chk(8'(d[`EV_RX_TRIG]), 8'h01);
    for (int k = 1; k < 4; k++) begin
      wr(`REG_FIFO_CTRL, 8'(k));
      wr(`REG_IRQ_STATUS, 8'h01);
      rd(`REG_IRQ_STATUS, d);
      chk(8'(d[`EV_RX_TRIG]), 8'h00);
    end
    wr(`REG_FIFO_CTRL, 8'h00);
    rc(`REG_DATA, 8'h5A);
    u_remote_line.send(8'h5A, 1'h1, 1'h1, 1'h0);
    wait_rx;
    rc(`REG_LINE_STATUS, 8'h1B);
    rc(`REG_DATA, 8'h5A);
    u_remote_line.park(1'h0);
    step(BT / 4);
    u_remote_line.park(1'h1);
    step(2 * BT);
    chk(8'(rx_avail_flag), 8'h00);
  endtask
  task automatic t_irq;
    wr(`REG_IRQ_MASK, 8'h0C);
    step(6);
    chk(8'(irq), 8'h01);
    @(posedge mclk);
    irq_style_select <= 1'h0;
    step(6);
    chk(8'(irq), 8'h00);
    wr(`REG_MODEM_CTRL, 8'h08);
    step(4);
    chk(8'(irq), 8'h01);
    wr(`REG_IRQ_STATUS, 8'h0C);
    step(4);
    chk(8'(irq), 8'h00);
    @(posedge mclk);
    irq_style_select <= 1'h1;
    wr(`REG_MODEM_CTRL, 8'h00);
    wr(`REG_IRQ_MASK, 8'h00);
  endtask
  task automatic t_flow;
    wr(`REG_FLOW, 8'h01);
    u_remote_line.send(8'h11, 1'h1, 1'h0, 1'h1);
    wait_rx;
    chk(8'(flow_suspended), 8'h01);
    wr(`REG_MODEM_CTRL, 8'h20);
    u_remote_line.send(8'h11, 1'h1, 1'h0, 1'h1);
    step(4);
    chk(8'(flow_suspended), 8'h00);
    drain;
    wr(`REG_MODEM_CTRL, 8'h00);
  endtask
  task automatic t_ir;
    wr(`REG_LINE_CTRL, 8'h00);
    wr(`REG_MODEM_CTRL, 8'h40);
    ir <= 1'h1;
    u_remote_line.park(1'h0);
    // switching modes with the line high frames one stray character; let it finish
    step(20 * BT);
    chk(8'(serial_out_line), 8'h00);
    drain;
    u_remote_line.send(8'h0F, 1'h0, 1'h0, 1'h1);
    wait_rx;
    rc(`REG_DATA, 8'h0F);
    wr(`REG_MODEM_CTRL, 8'h00);
    ir <= 1'h0;
    u_remote_line.park(1'h1);
    step(4 * BT);
    drain;
  endtask
  task automatic t_monitor;
    rc(`REG_MONITOR, 8'h6B);
    @(posedge mclk);
    other_rx_avail_flag <= 4'h9;
    other_tx_space_flag <= 4'h4;
    rc(`REG_MONITOR, 8'h85);
  endtask
  // transmitter disabled so the fifo only fills; the run ends without draining it
  task automatic t_fill;
    for (int i = 0; i < 127; i++) wr(`REG_DATA, 8'(i));
    step(2);
    chk(8'(tx_space_flag), 8'h01);
    wr(`REG_DATA, 8'hFF);
    step(2);
    chk(8'(tx_space_flag), 8'h00);
    chk(8'(serial_out_line), 8'h01);
  endtask
  // a mid-run reset with the strap low: bit 7 must come back clear
  task automatic t_strap;
    @(posedge mclk);
    prescale_default_select <= 1'h0;
    rst <= 1'h1;
    step(2);
    chk(8'(serial_out_line), 8'h01);
    @(posedge mclk);
    rst <= 1'h0;
    repeat (4) @(posedge mclk);
    rc(`REG_MODEM_CTRL, 8'h00);
    rc(`REG_LINE_STATUS, 8'h02);
  endtask
  ////////////////////////////////////////
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    rst <= 1'h1;
    step(1);
    chk(8'(serial_out_line), 8'h01);
    @(posedge mclk);
    rst <= 1'h0;
    repeat (4) @(posedge mclk);
    t_reset;
    t_wire;
    t_loop;
    t_rx;
    t_irq;
    t_flow;
    t_ir;
    t_monitor;
    t_fill;
    t_strap;
    final_report;
  end
endmodule
